// >>> logic/adt_pkg.sv
// Purpose: shared constants and types of the converter register block
// Assumes: apb with 32-bit data, one register per aligned word
// Notes:   offsets are byte addresses
package adt_pkg;

  localparam logic [11:0] OFS_CTRL0   = 12'h000;
  localparam logic [11:0] OFS_CTRL1   = 12'h004;
  localparam logic [11:0] OFS_RES_HI  = 12'h008;
  localparam logic [11:0] OFS_RES_LO  = 12'h00c;
  localparam logic [11:0] OFS_REFTEMP = 12'h010;
  localparam logic [11:0] OFS_IRQ_ST  = 12'h014;
  localparam logic [11:0] OFS_IRQ_MSK = 12'h018;
  localparam logic [11:0] OFS_SAMPLE  = 12'h01c;

  // converter_control_0 and control 1 fields
  localparam int unsigned CTL0_ON_BIT  = 0;
  localparam int unsigned CTL0_GO_BIT  = 1;
  localparam int unsigned CTL0_CHS_LSB = 2;
  localparam int unsigned CTL0_CHS_MSB = 6;
  localparam logic [7:0]  CTL0_WMASK   = 8'h7f;
  localparam logic [7:0]  CTL1_WMASK   = 8'hf7;
  localparam int unsigned CTL1_JUST_BIT = 7;

  // reference_and_temp_control fields
  localparam int unsigned REF_EN_BIT   = 7;
  localparam int unsigned REF_RDY_BIT  = 6;
  localparam int unsigned TS_EN_BIT    = 5;
  localparam int unsigned TS_RNG_BIT   = 4;
  localparam logic [7:0]  REF_WMASK    = 8'hbf;

  localparam logic [4:0]  CHAN_TEMP    = 5'h1d;
  localparam logic [7:0]  RESET_ZERO   = 8'h00;

  // conversion takes this many clk_sys cycles (bits plus sample)
  localparam int unsigned CONV_STEPS   = 11;
  localparam int unsigned REF_SETTLE   = 16;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] refctl;
  } adt_cfg_s;

  typedef enum logic [1:0] {
    ADT_IDLE,
    ADT_CONV,
    ADT_LOAD
  } adt_state_e;

endpackage

// >>> logic/adt_ctrl.sv
// Purpose: register side of a 10-bit converter with on-die temperature indicator
// Assumes: conversion data arrives on an analog-front-end sample port
// Notes:   result bytes have no reset, keeping contents across resets
//
// Local design decisions: register access over APB and the register addresses.
module adt_ctrl
  import adt_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [9:0]  conversion_sample,
  output logic      [4:0]  channel_select,
  output logic             temp_mux_select,
  output logic             temp_sense_power,
  output logic             temp_sense_high_range,
  output logic             converter_power,
  output logic             sample_hold,
  output logic             irq
);

  logic        rst_meta_q;
  logic        rst_sync_q;
  adt_cfg_s    cfg_q;
  logic [7:0]  res_hi_q;
  logic [7:0]  res_lo_q;
  logic [1:0]  irq_st_q;
  logic [1:0]  irq_msk_q;
  logic        ref_rdy_q;
  logic [4:0]  settle_q;
  logic [3:0]  step_q;
  adt_state_e  state_q;
  logic        wr_en;
  logic        rd_en;
  logic        done_pulse;
  logic        go_set;
  logic        hit;
  logic [31:0] rd_data;
  logic [31:0] prdata_q;

  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign pready  = 1'b1;
  assign hit     = is_reg(paddr, OFS_CTRL0) || is_reg(paddr, OFS_CTRL1) ||
                   is_reg(paddr, OFS_RES_HI) || is_reg(paddr, OFS_RES_LO) ||
                   is_reg(paddr, OFS_REFTEMP) || is_reg(paddr, OFS_IRQ_ST) ||
                   is_reg(paddr, OFS_IRQ_MSK) || is_reg(paddr, OFS_SAMPLE);
  assign pslverr = psel && penable && !hit;
  assign go_set  = wr_en && is_reg(paddr, OFS_CTRL0) && pwdata[CTL0_GO_BIT] &&
                   pwdata[CTL0_ON_BIT] && state_q == ADT_IDLE;
  assign done_pulse = state_q == ADT_LOAD;

  // configuration registers; go cleared by hardware at load
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cfg_q <= '{ctrl0: RESET_ZERO, ctrl1: RESET_ZERO, refctl: RESET_ZERO};
    end else begin
      if (wr_en && is_reg(paddr, OFS_CTRL0)) begin
        cfg_q.ctrl0 <= pwdata[7:0] & CTL0_WMASK;
        if (state_q != ADT_IDLE) begin
          // go may only stay set while on stays set and no load is ending
          cfg_q.ctrl0[CTL0_GO_BIT] <= pwdata[CTL0_GO_BIT] && pwdata[CTL0_ON_BIT] &&
                                      !done_pulse;
        end else begin
          cfg_q.ctrl0[CTL0_GO_BIT] <= go_set;
        end
      end else if (done_pulse) begin
        cfg_q.ctrl0[CTL0_GO_BIT] <= 1'b0;
      end
      if (wr_en && is_reg(paddr, OFS_CTRL1)) begin
        cfg_q.ctrl1 <= pwdata[7:0] & CTL1_WMASK;
      end
      if (wr_en && is_reg(paddr, OFS_REFTEMP)) begin
        cfg_q.refctl <= pwdata[7:0] & REF_WMASK;
      end
    end
  end

  // conversion sequencer; clearing go aborts a running conversion
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ADT_IDLE;
      step_q  <= '0;
    end else begin
      unique case (state_q)
        ADT_IDLE: begin
          step_q <= '0;
          if (go_set) begin
            state_q <= ADT_CONV;
          end
        end
        ADT_CONV: begin
          if (!cfg_q.ctrl0[CTL0_GO_BIT] || !cfg_q.ctrl0[CTL0_ON_BIT]) begin
            state_q <= ADT_IDLE;
          end else if (step_q == 4'(CONV_STEPS - 1)) begin
            state_q <= ADT_LOAD;
          end else begin
            step_q <= step_q + 4'h1;
          end
        end
        ADT_LOAD: begin
          state_q <= ADT_IDLE;
        end
      endcase
    end
  end

  // result bytes: no reset, so contents survive any reset
  always_ff @(posedge clk_sys) begin
    if (done_pulse) begin
      if (cfg_q.ctrl1[CTL1_JUST_BIT]) begin
        res_hi_q <= {6'h00, conversion_sample[9:8]};
        res_lo_q <= conversion_sample[7:0];
      end else begin
        res_hi_q <= conversion_sample[9:2];
        res_lo_q <= {conversion_sample[1:0], 6'h00};
      end
    end else begin
      if (wr_en && is_reg(paddr, OFS_RES_HI)) begin
        res_hi_q <= pwdata[7:0];
      end
      if (wr_en && is_reg(paddr, OFS_RES_LO)) begin
        res_lo_q <= pwdata[7:0];
      end
    end
  end

  // fixed reference ready after a settle count
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      settle_q  <= '0;
      ref_rdy_q <= 1'b0;
    end else if (!cfg_q.refctl[REF_EN_BIT]) begin
      settle_q  <= '0;
      ref_rdy_q <= 1'b0;
    end else if (settle_q == 5'(REF_SETTLE - 1)) begin
      ref_rdy_q <= 1'b1;
    end else begin
      settle_q <= settle_q + 5'h01;
    end
  end

  // sticky status: bit0 conversion done, bit1 reference ready; set wins
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      irq_st_q  <= '0;
      irq_msk_q <= '0;
    end else begin
      if (wr_en && is_reg(paddr, OFS_IRQ_MSK)) begin
        irq_msk_q <= pwdata[1:0];
      end
      irq_st_q[0] <= done_pulse ||
                     (irq_st_q[0] && !(wr_en && is_reg(paddr, OFS_IRQ_ST) && pwdata[0]));
      irq_st_q[1] <= (cfg_q.refctl[REF_EN_BIT] && !ref_rdy_q &&
                      settle_q == 5'(REF_SETTLE - 1)) ||
                     (irq_st_q[1] && !(wr_en && is_reg(paddr, OFS_IRQ_ST) && pwdata[1]));
    end
  end

  assign irq = |(irq_st_q & irq_msk_q);

  // read mux, captured in the setup cycle so prdata comes from a flop
  always_comb begin
    rd_data = '0;
    unique case (1'b1)
      is_reg(paddr, OFS_CTRL0):   rd_data[7:0] = cfg_q.ctrl0;
      is_reg(paddr, OFS_CTRL1):   rd_data[7:0] = cfg_q.ctrl1;
      is_reg(paddr, OFS_RES_HI):  rd_data[7:0] = res_hi_q;
      is_reg(paddr, OFS_RES_LO):  rd_data[7:0] = res_lo_q;
      is_reg(paddr, OFS_REFTEMP): begin
        rd_data[7:0] = cfg_q.refctl;
        rd_data[REF_RDY_BIT] = ref_rdy_q;
      end
      is_reg(paddr, OFS_IRQ_ST):  rd_data[1:0] = irq_st_q;
      is_reg(paddr, OFS_IRQ_MSK): rd_data[1:0] = irq_msk_q;
      is_reg(paddr, OFS_SAMPLE):  rd_data[CTL0_ON_BIT] = state_q != ADT_IDLE;
      default:                    rd_data = '0;
    endcase
  end

  // held through the access phase, zero outside reads
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      prdata_q <= '0;
    end else if (rd_en && !penable) begin
      prdata_q <= rd_data;
    end else if (!(psel && penable)) begin
      prdata_q <= '0;
    end
  end

  assign prdata = prdata_q;

  assign channel_select        = cfg_q.ctrl0[CTL0_CHS_MSB:CTL0_CHS_LSB];
  assign temp_mux_select       = channel_select == CHAN_TEMP;
  assign temp_sense_power      = cfg_q.refctl[TS_EN_BIT];
  assign temp_sense_high_range = cfg_q.refctl[TS_RNG_BIT];
  assign converter_power       = cfg_q.ctrl0[CTL0_ON_BIT];
  assign sample_hold           = state_q != ADT_IDLE;

endmodule

// >>> bench/adt_ctrl_properties.sv
// Purpose: port assertions of adt_ctrl
// Assumes: zero-wait apb slave, one clock domain
// Notes:   attached by bind from the bench top
module adt_ctrl_properties
  import adt_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [9:0]  conversion_sample,
  input wire logic [4:0]  channel_select,
  input wire logic        temp_mux_select,
  input wire logic        temp_sense_power,
  input wire logic        temp_sense_high_range,
  input wire logic        converter_power,
  input wire logic        sample_hold,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic wr_c0;
  logic wr_rt;
  assign wr_c0 = psel && penable && pwrite && paddr == OFS_CTRL0;
  assign wr_rt = psel && penable && pwrite && paddr == OFS_REFTEMP;
  temp_mux_a: assert property (temp_mux_select == (channel_select == CHAN_TEMP))
    else $error("temp mux select does not follow channel");
  ts_power_a: assert property (wr_rt |=> temp_sense_power == $past(pwdata[TS_EN_BIT]))
    else $error("indicator power does not follow enable bit");
  ts_range_a: assert property (wr_rt |=> temp_sense_high_range == $past(pwdata[TS_RNG_BIT]))
    else $error("indicator range does not follow range bit");
  chan_sel_a: assert property (wr_c0 |=> channel_select == $past(pwdata[6:2]))
    else $error("channel select not loaded");
  go_start_a: assert property (wr_c0 && pwdata[1:0] == 2'b11 |=> sample_hold)
    else $error("conversion did not start");
  conv_end_a: assert property ($rose(sample_hold) |-> ##[10:16] !sample_hold)
    else $error("conversion did not finish");
  conv_on_a: assert property (wr_c0 |=> converter_power == $past(pwdata[0]))
    else $error("converter power not loaded");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase not answered");
  bad_addr_a: assert property (psel && penable && paddr > OFS_SAMPLE |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  cover property ($fell(sample_hold));
  cover property (irq);
  cover property (temp_mux_select && temp_sense_power);
endmodule

// >>> bench/test_adt_ctrl.sv
// Purpose: self-checking bench of adt_ctrl
// Assumes: zero-wait apb, 8-bit registers in aligned words
// Notes:   acquisition wait kept short for run time
module test_adt_ctrl
  import adt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, temp_mux_select, temp_sense_power, temp_sense_high_range;
  logic        converter_power, sample_hold, irq, e;
  logic [9:0]  conversion_sample = 10'h000;
  logic [4:0]  channel_select;
  logic [7:0]  r;
  int          fail_count = 0, compares = 0, cyc = 0;
  adt_ctrl dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .conversion_sample, .channel_select, .temp_mux_select,
    .temp_sense_power, .temp_sense_high_range, .converter_power, .sample_hold, .irq);
  always #25 clk_sys = ~clk_sys;
  task test_done;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done;
    end
  end
  task chk(input logic [7:0] s, input logic [7:0] x);
    compares++;
    if (s !== x) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task conv(input logic j, input logic [9:0] s, input logic [7:0] eh, input logic [7:0] el);
    apb(1, OFS_CTRL1, {j, 7'h00});
    apb(1, OFS_RES_HI, 8'hff);
    conversion_sample <= s;
    apb(1, OFS_CTRL0, 8'h05);
    repeat (100) @(posedge clk_sys);
    apb(1, OFS_CTRL0, 8'h07);
    apb(0, OFS_SAMPLE, 8'h00);
    chk(r, 8'h01);
    do begin
      apb(0, OFS_CTRL0, 8'h00);
    end while (r[1] !== 1'b0);
    apb(0, OFS_RES_HI, 8'h00);
    chk(r, eh);
    apb(0, OFS_RES_LO, 8'h00);
    chk(r, el);
  endtask
  task temp_ctrl;
    for (int i = 0; i < 4; i++) begin
      apb(1, OFS_REFTEMP, {2'b00, i[1:0], 4'h0});
      @(negedge clk_sys);
      chk({6'h0, temp_sense_power, temp_sense_high_range}, {6'h0, i[1:0]});
    end
    apb(1, OFS_CTRL0, {1'b0, CHAN_TEMP, 2'b01});
    @(negedge clk_sys);
    chk({2'h0, temp_mux_select, channel_select}, {3'h1, CHAN_TEMP});
  endtask
  task ref_ready;
    apb(1, OFS_IRQ_MSK, 8'h02);
    apb(1, OFS_REFTEMP, 8'h80);
    repeat (REF_SETTLE) @(posedge clk_sys);
    apb(0, OFS_REFTEMP, 8'h00);
    chk(r, 8'hc0);
    @(negedge clk_sys);
    chk({7'h0, irq}, 8'h01);
    apb(1, OFS_IRQ_ST, 8'h02);
    @(negedge clk_sys);
    chk({7'h0, irq}, 8'h00);
  endtask
  task irq_keep;
    apb(1, OFS_IRQ_MSK, 8'h00);
    @(negedge clk_sys);
    chk({7'h0, irq}, 8'h00);
    apb(1, OFS_IRQ_MSK, 8'h01);
    @(negedge clk_sys);
    chk({7'h0, irq}, 8'h01);
    apb(1, OFS_IRQ_ST, 8'h01);
    @(negedge clk_sys);
    chk({7'h0, irq}, 8'h00);
    apb(0, 12'h020, 8'h00);
    chk({6'h0, e, r[0]}, 8'h02);
    nrst <= 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1;
    repeat (4) @(posedge clk_sys);
    apb(0, OFS_RES_LO, 8'h00);
    chk(r, 8'h80);
    apb(0, OFS_CTRL0, 8'h00);
    chk(r, 8'h00);
    apb(1, OFS_CTRL0, 8'h02);
    apb(0, OFS_CTRL0, 8'h00);
    chk(r, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1;
    repeat (4) @(posedge clk_sys);
    temp_ctrl;
    conv(1, 10'h3a5, 8'h03, 8'ha5);
    conv(0, 10'h2b6, 8'had, 8'h80);
    ref_ready;
    irq_keep;
    test_done;
  end
endmodule
bind adt_ctrl adt_ctrl_properties u_prop (.clk_sys, .nrst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .conversion_sample, .channel_select,
  .temp_mux_select, .temp_sense_power, .temp_sense_high_range, .converter_power,
  .sample_hold, .irq);
